/* File: bench/ir_carrier_modulation_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module ir_carrier_modulation_timer_test import irt_pkg::*; ();
   logic        clk_sys, reset, reg_wr, reg_rd, rx_pin;
   logic        tx_pin, tx_oe_n, env_pin, irq, p, b;
   logic [7:0]  reg_addr, h, l;
   logic [31:0] reg_wdata, reg_rdata, d, q;
   logic [1:0]  dv;
   logic [15:0] mt;
   int          bad_count, checks, seed, t0, a1, a2, a3, ex;
   int          cyc = 0;

   irt_top dut_u (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IR_RX_PIN(rx_pin),
      .IR_TX_PIN(tx_pin), .IR_TX_OE_N(tx_oe_n), .ENVELOPE_OUT_PIN(env_pin), .IR_IRQ(irq));
   irt_ir_peer peer_u (.clk(clk_sys), .tx_level(tx_pin), .tx_oe_n(tx_oe_n), .rx_level(rx_pin));

   ////////////////////////////////////////////////////////////////////////////
   // Free-running clock and a cycle count for interval timing.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   // A tolerance of one covers the capture landing before or after that count step.
   task chk(input string nm, input logic [31:0] exp, got, input int tol = 0);
      checks++;
      if (!(got === exp || (tol > 0 && got === exp - 32'h1))) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task results();
      $display("Counts: %0d comparisons, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // A lost interrupt must not hang the run.
   task wait_irq();
      int n;
      n = 0;
      #1;
      while (irq !== 1'b1) begin
         @(posedge clk_sys);
         #1 n++;
         if (n > 5000) begin
            bad_count++;
            $display("CHECK FAILED irq expected 1 seen %0h", irq);
            results();
         end
      end
   endtask : wait_irq

   function automatic int run_len(input logic [7:0] c, input logic [1:0] div);
      return (int'(c) + 1) << div;
   endfunction : run_len

   // Control word with enable and interrupt enable set.
   function automatic logic [31:0] ctl(input logic md, ck, pl, dt, input logic [1:0] dv, ev, eg,
                                       input logic rl, bu);
      ctl                   = 32'h0;
      ctl[IRT_EN]           = 1'b1;
      ctl[IRT_IE]           = 1'b1;
      ctl[IRT_MODE]         = md;
      ctl[IRT_CKSEL]        = ck;
      ctl[IRT_POL]          = pl;
      ctl[IRT_DATA]         = dt;
      ctl[IRT_DIV_LO +: 2]  = dv;
      ctl[IRT_ENV_LO +: 2]  = ev;
      ctl[IRT_EDG_LO +: 2]  = eg;
      ctl[IRT_RELOAD]       = rl;
      ctl[IRT_BURST]        = bu;
   endfunction : ctl

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      seed = 32'h26E055F8;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      #1 chk("reset pins", 32'h4, {28'h0, tx_pin, tx_oe_n, env_pin, irq});
      rd(IRT_CTRL_ADDR, q);
      chk("ctrl reset", 32'h0, q);
      rd(8'h18, q);
      chk("unmapped", 32'h0, q);
      for (int k = 0; k < 3; k++) begin
         d = {16'h0, 16'($random(seed))};
         wr(IRT_CARR_ADDR + 8'(k * 4), d);
         rd(IRT_CARR_ADDR + 8'(k * 4), q);
         chk("readback", d, q);
      end
      $display("registers done");
      // Disabled: software drives the pin, transmit mode alone sends nothing.
      wr(IRT_CTRL_ADDR, 32'h2);
      for (int k = 0; k < 4; k++) begin
         wr(IRT_PWRC_ADDR, 32'(k));
         repeat (2) @(posedge clk_sys);
         #1 chk("manual oe", {31'h0, ~k[1]}, {31'h0, tx_oe_n});
         if (k[1]) chk("manual level", {31'h0, k[0]}, {31'h0, tx_pin});
      end
      peer_u.clear();
      repeat (50) @(posedge clk_sys);
      chk("edges while off", 32'h0, peer_u.edges);
      for (int k = 0; k < 2; k++) begin
         wr(IRT_CTRL_ADDR, ctl(1'b0, 1'b0, k[0], 1'b0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0));
         repeat (3) @(posedge clk_sys);
         #1 chk("idle level", {30'h0, k[0], 1'b0}, {30'h0, tx_pin, tx_oe_n});
      end
      $display("pin control done");
      // Carrier shape: plain, inverted, unmodulated envelope, idle.
      for (int c = 0; c < 4; c++) begin
         h = 8'($random(seed)) & 8'h03;
         l = 8'($random(seed)) & 8'h03;
         dv = 2'(($random(seed) & 32'h7FFF) % 3);
         wr(IRT_CTRL_ADDR, 32'h0);
         wr(IRT_CARR_ADDR, {16'h0, h, l});
         wr(IRT_MODT_ADDR, 32'hFFFF);
         wr(IRT_CTRL_ADDR, ctl(1'b1, 1'b0, c == 1, c < 2, dv, (c == 2) ? 2'h2 : 2'h0, 2'h0, 1'b0, 1'b0));
         repeat (8) @(posedge clk_sys);
         #1 peer_u.clear();
         repeat (120) @(posedge clk_sys);
         #1;
         if (c == 3) chk("idle edges", 32'h0, peer_u.edges);
         else begin
            chk("high run", run_len(c == 1 ? l : h, dv), peer_u.hi_run);
            chk("low run", run_len(c == 1 ? h : l, dv), peer_u.lo_run);
         end
      end
      $display("carrier done");
      // Interval timing on input clocks, with data changed in mid-interval.
      wr(IRT_CTRL_ADDR, 32'h0);
      wr(IRT_STAT_ADDR, 32'h3);
      mt = 16'(8 + ($random(seed) & 31));
      p = 1'($random(seed));
      b = 1'($random(seed));
      wr(IRT_MODT_ADDR, {16'h0, mt});
      wr(IRT_CTRL_ADDR, ctl(1'b1, 1'b1, p, b, 2'h0, 2'h1, 2'h0, 1'b0, 1'b0));
      wait_irq();
      t0 = cyc;
      repeat (2) @(posedge clk_sys);
      #1 chk("envelope", {31'h0, b ^ p}, {31'h0, env_pin});
      wr(IRT_CTRL_ADDR, ctl(1'b1, 1'b1, p, ~b, 2'h0, 2'h1, 2'h0, 1'b0, 1'b0));
      wr(IRT_STAT_ADDR, 32'h3);
      #1 chk("envelope held", {31'h0, b ^ p}, {31'h0, env_pin});
      wait_irq();
      chk("interval", 32'(mt) + 32'h1, cyc - t0);
      repeat (2) @(posedge clk_sys);
      #1 chk("envelope next", {31'h0, ~b ^ p}, {31'h0, env_pin});
      // Interval timing on carrier cycles; the second interval avoids the start-up phase.
      wr(IRT_CTRL_ADDR, 32'h0);
      wr(IRT_STAT_ADDR, 32'h3);
      wr(IRT_CARR_ADDR, {16'h0, h, l});
      mt = 16'(4 + ($random(seed) & 7));
      wr(IRT_MODT_ADDR, {16'h0, mt});
      wr(IRT_CTRL_ADDR, ctl(1'b1, 1'b0, p, b, dv, 2'h0, 2'h0, 1'b0, 1'b0));
      wait_irq();
      t0 = cyc;
      wr(IRT_STAT_ADDR, 32'h3);
      wait_irq();
      chk("carrier interval", (32'(mt) + 32'h1) * 32'(run_len(h, dv) + run_len(l, dv)), cyc - t0);
      $display("modulation done");
      // Capture with each edge selection; the last pass runs both edges without reload.
      a1 = 6 + ($random(seed) & 15);
      a2 = 6 + ($random(seed) & 15);
      a3 = 6 + ($random(seed) & 15);
      for (int e = 1; e < 5; e++) begin
         wr(IRT_CTRL_ADDR, 32'h0);
         wr(IRT_STAT_ADDR, 32'h3);
         wr(IRT_CTRL_ADDR, ctl(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'((e == 4) ? 3 : e), e < 4, 1'b0));
         peer_u.send(1'b1, a1);
         peer_u.send(1'b0, a2);
         peer_u.send(1'b1, a3);
         peer_u.send(1'b0, 10);
         ex = (e == 1) ? a1 + a2 : (e == 2) ? a2 + a3 : (e == 3) ? a3 : a1 + a2 + a3;
         rd(IRT_MODT_ADDR, q);
         chk("capture", ex, q, 1);
         rd(IRT_CTRL_ADDR, q);
         chk("level", {31'h0, e == 1}, {31'h0, q[IRT_DATA]});
      end
      wr(IRT_STAT_ADDR, 32'h3);
      repeat (65600) @(posedge clk_sys);
      rd(IRT_STAT_ADDR, q);
      chk("overflow", 32'h1, {31'h0, q[IRT_ST_OV]});
      chk("overflow irq", 32'h1, {31'h0, irq});
      $display("receive done");
      // Burst counting of rising edges, then a carrier gap.
      wr(IRT_CTRL_ADDR, 32'h0);
      wr(IRT_CARR_ADDR, 32'h0101);
      wr(IRT_CTRL_ADDR, ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h1, 1'b0, 1'b1));
      rd(IRT_MODT_ADDR, q);
      chk("burst start", 32'h1, q);
      wr(IRT_STAT_ADDR, 32'h3);
      ex = 2 + ($random(seed) & 3);
      repeat (ex) begin
         peer_u.send(1'b1, 2);
         peer_u.send(1'b0, 2);
      end
      repeat (40) @(posedge clk_sys);
      rd(IRT_MODT_ADDR, q);
      chk("burst count", ex + 1, q);
      rd(IRT_STAT_ADDR, q);
      chk("gap flag", 32'h1, {31'h0, q[IRT_ST_IF]});
      $display("burst done");
      results();
   end
endmodule : ir_carrier_modulation_timer_test
`default_nettype wire

/* File: bench/irt_ir_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module irt_ir_peer (
   // Clock shared with the device.
   input  wire logic clk,
   // Emitter drive coming from the device.
   input  wire logic tx_level,
   input  wire logic tx_oe_n,
   // Receiver module output toward the device.
   output var  logic rx_level
);
   logic last_r;
   int   run;
   int   hi_run;
   int   lo_run;
   int   edges;

   initial begin
      rx_level = 1'b0;
      last_r   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // The LED only lights while driven, so runs are timed on driven cycles only.
   always @(posedge clk) begin
      if (!tx_oe_n) begin
         if (tx_level === last_r) begin
            run++;
         end else begin
            if (last_r) hi_run = run;
            else lo_run = run;
            run = 1;
            edges++;
         end
         last_r = tx_level;
      end
   end

   // Forget earlier runs; the first run after this is partial and is overwritten.
   task clear();
      run    = 0;
      hi_run = 0;
      lo_run = 0;
      edges  = 0;
   endtask : clear

   // The receiver output changes after an edge and holds for a number of cycles.
   task send(input logic lvl, input int hold);
      @(posedge clk);
      rx_level <= lvl;
      repeat (hold - 1) @(posedge clk);
   endtask : send
endmodule : irt_ir_peer
`default_nettype wire

/* File: include/irt_pkg.sv */
// How it works
// - While disabled, the transmit pin follows software level and enable bits.
// - The timer runs only when enabled; its mode bit selects the modulator.
// - Counter rollover from FFFF to 0000 sets overflow and may interrupt.
// - Input clock is system clock divided by two to the divider field.
// - Carrier high lasts high byte plus one, low lasts low byte plus one.
// - Carrier, data and polarity are latched at each interval start.
// - When enabled, the pin idles at the polarity bit level.
// - Down counter steps on carrier cycles or on input clocks.
// - Latched data one sends carrier, inverted when polarity set; zero sends idle.
// - Transmit starts on enable or mode set, sampling settings at start.
// - At zero the counter reloads, resamples, updates output, sets flag.
// - Each interval lasts modulation time plus one counter clocks.
// - Envelope modes drive envelope pin with data, inverted when polarity set.
// - Envelope 01 sends modulated carrier, 10 sends plain carrier on transmit pin.
// - Edge-select field picks which receive edges qualify.
// - Receive counting starts from 0000 at the first qualified edge.
// - Receive counter steps on carrier cycles or on input clocks.
// - Later edges store level, copy counter, optionally clear it, keep counting.
// - Receive continues until stopped; rollover before an edge sets overflow.
// - Burst mode counts edges; flag when two carrier cycles lack edges.
// - Burst mode turning on loads modulation time with 0001.
package irt_pkg;
   // Register byte addresses.
   localparam logic [7:0] IRT_CTRL_ADDR = 8'h00;
   localparam logic [7:0] IRT_STAT_ADDR = 8'h04;
   localparam logic [7:0] IRT_CARR_ADDR = 8'h08;
   localparam logic [7:0] IRT_MODT_ADDR = 8'h0C;
   localparam logic [7:0] IRT_CNTV_ADDR = 8'h10;
   localparam logic [7:0] IRT_PWRC_ADDR = 8'h14;
   // Control field positions.
   localparam int IRT_EN     = 0;
   localparam int IRT_MODE   = 1;
   localparam int IRT_CKSEL  = 2;
   localparam int IRT_POL    = 3;
   localparam int IRT_DATA   = 4;
   localparam int IRT_DIV_LO = 5;
   localparam int IRT_ENV_LO = 7;
   localparam int IRT_EDG_LO = 9;
   localparam int IRT_RELOAD = 11;
   localparam int IRT_BURST  = 12;
   localparam int IRT_IE     = 13;
   localparam int IRT_CTRL_W = 14;
   // Status and power-control bits.
   localparam int IRT_ST_IF  = 0;
   localparam int IRT_ST_OV  = 1;
   localparam int IRT_PW_LVL = 0;
   localparam int IRT_PW_OE  = 1;
   // Reset values and constants.
   localparam logic [13:0] IRT_CTRL_RST = 14'h0000;
   localparam logic [15:0] IRT_W16_ZERO = 16'h0000;
   localparam logic [15:0] IRT_W16_ONE  = 16'h0001;
   localparam logic [15:0] IRT_W16_MAX  = 16'hFFFF;
   localparam logic [1:0]  IRT_ENV_MOD  = 2'h1;
   localparam logic [1:0]  IRT_ENV_RAW  = 2'h2;
   localparam logic [1:0]  IRT_EDG_RISE = 2'h1;
   localparam logic [1:0]  IRT_EDG_FALL = 2'h2;
   localparam logic [1:0]  IRT_EDG_BOTH = 2'h3;
   localparam logic [1:0]  IRT_GAP_LIM  = 2'h2;
endpackage : irt_pkg

/* File: rtl/irt_top.sv */
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module irt_top
   import irt_pkg::*;
(
   // Clock and reset.
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   // Register port.
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output var  logic [31:0] REG_RDATA,
   // Infrared pins.
   input  wire logic        IR_RX_PIN,
   output var  logic        IR_TX_PIN,
   output var  logic        IR_TX_OE_N,
   output var  logic        ENVELOPE_OUT_PIN,
   // Interrupt request level.
   output logic             IR_IRQ
);

   // Decrement or increment of a 16-bit count.
   function automatic logic [15:0] irt_step(input logic [15:0] v,
                                             input logic up);
      irt_step = up ? 16'(v + IRT_W16_ONE) : 16'(v - IRT_W16_ONE);
   endfunction : irt_step

   ////////////////////////////////////////////////////////////////
   // State.
   logic [13:0] ctrl_r;
   logic [15:0] carr_r;
   logic [15:0] modt_r;
   logic [15:0] cntv_r;
   logic [1:0]  pwr_r;
   logic        intf_r;
   logic        ovfl_r;
   logic [2:0]  pre_r;
   logic        phase_r;
   logic [7:0]  ccnt_r;
   logic [15:0] carl_r;
   logic        datl_r;
   logic        poll_r;
   logic        txrun_q_r;
   logic        rx_s1_r;
   logic        rx_s2_r;
   logic        rx_s3_r;
   logic        started_r;
   logic [1:0]  gap_r;
   logic [31:0] rdata_r;
   logic        tx_r;
   logic        oen_r;
   logic        env_r;

   ////////////////////////////////////////////////////////////////
   // Register decode.
   wire wr_ctrl = REG_WR && (REG_ADDR == IRT_CTRL_ADDR);
   wire wr_stat = REG_WR && (REG_ADDR == IRT_STAT_ADDR);
   wire wr_carr = REG_WR && (REG_ADDR == IRT_CARR_ADDR);
   wire wr_modt = REG_WR && (REG_ADDR == IRT_MODT_ADDR);
   wire wr_cntv = REG_WR && (REG_ADDR == IRT_CNTV_ADDR);
   wire wr_pwrc = REG_WR && (REG_ADDR == IRT_PWRC_ADDR);
   wire [15:0] wd16 = REG_WDATA[15:0];

   // Control fields.
   wire       en     = ctrl_r[IRT_EN];
   wire       mode   = ctrl_r[IRT_MODE];
   wire       cksel  = ctrl_r[IRT_CKSEL];
   wire       pol    = ctrl_r[IRT_POL];
   wire [1:0] div    = ctrl_r[IRT_DIV_LO +: 2];
   wire [1:0] envsel = ctrl_r[IRT_ENV_LO +: 2];
   wire [1:0] edgsel = ctrl_r[IRT_EDG_LO +: 2];
   wire       reload = ctrl_r[IRT_RELOAD];
   wire       burst  = ctrl_r[IRT_BURST];
   wire       ie     = ctrl_r[IRT_IE];

   ////////////////////////////////////////////////////////////////
   // Input clock tick: a free prescaler, masked by the divider.
   wire [2:0] pmask = 3'((4'h1 << div) - 4'h1);
   wire tick = ((pre_r & pmask) == pmask);

   // Run states and transmit start.
   wire tx_run   = en && mode;
   wire rx_run   = en && !mode;
   wire tx_start = tx_run && !txrun_q_r;

   // Carrier generator: the phase counter runs down, then flips.
   wire car_end = tick && (ccnt_r == 8'h00) && !phase_r;
   wire cclk    = cksel ? tick : car_end;
   wire tx_rel  = tx_run && !tx_start && cclk
                  && (cntv_r == IRT_W16_ZERO);
   wire tx_lat  = tx_start || tx_rel;
   wire [15:0] carl_nxt = tx_lat ? carr_r : carl_r;
   wire [15:0] car_src  = tx_run ? carl_nxt : carr_r;
   wire gen_rst = !en || tx_start;
   wire phase_nxt = gen_rst ? 1'b1
                  : (tick && ccnt_r == 8'h00) ? !phase_r
                  : phase_r;
   wire [7:0] ccnt_nxt = gen_rst ? car_src[15:8]
                  : !tick ? ccnt_r
                  : (ccnt_r != 8'h00) ? 8'(ccnt_r - 8'h01)
                  : phase_r ? car_src[7:0]
                  : car_src[15:8];

   ////////////////////////////////////////////////////////////////
   // Receive edges, taken only from the synchronised copy.
   wire rise = rx_s2_r && !rx_s3_r;
   wire fall = !rx_s2_r && rx_s3_r;
   wire qual = rx_run && (((edgsel == IRT_EDG_RISE) && rise)
                       || ((edgsel == IRT_EDG_FALL) && fall)
                       || ((edgsel == IRT_EDG_BOTH)
                           && (rise || fall)));
   wire first_ev = qual && !started_r;
   wire later_ev = qual && started_r;
   wire capture  = later_ev && !burst;
   wire rx_inc   = rx_run && started_r && cclk;
   wire rollover = rx_inc && (cntv_r == IRT_W16_MAX)
                   && !later_ev;
   // An edge in the same cycle as the second carrier end still counts as carrier present.
   wire gap_ev   = rx_run && burst && started_r && car_end && !qual
                   && (gap_r == IRT_GAP_LIM - 2'h1);
   wire burst_on = wr_ctrl && REG_WDATA[IRT_BURST]
                   && !burst;

   ////////////////////////////////////////////////////////////////
   // Next values of software-visible registers.
   // Hardware updates take precedence over a write in the same cycle.
   wire [13:0] ctrl_w   = wr_ctrl ? REG_WDATA[13:0] : ctrl_r;
   wire [13:0] ctrl_nxt = capture
                        ? ((ctrl_w & ~(14'h1 << IRT_DATA))
                           | (14'(rx_s2_r) << IRT_DATA))
                        : ctrl_w;
   wire [15:0] cntv_nxt =
        tx_start ? modt_r
      : tx_rel   ? modt_r
      : (tx_run && cclk) ? irt_step(cntv_r, 1'b0)
      : first_ev ? IRT_W16_ZERO
      : (later_ev && reload) ? IRT_W16_ZERO
      : rx_inc   ? irt_step(cntv_r, 1'b1)
      : wr_cntv  ? wd16
      : cntv_r;
   wire [15:0] modt_nxt =
        burst_on ? IRT_W16_ONE
      : (rx_run && burst && qual)
                 ? irt_step(modt_r, 1'b1)
      : capture  ? cntv_r
      : wr_modt  ? wd16
      : modt_r;
   // A flag being set wins over a clear in the same cycle.
   wire if_set   = tx_rel || capture || gap_ev;
   wire intf_nxt = if_set
                 || (intf_r && !(wr_stat && REG_WDATA[IRT_ST_IF]));
   wire ovfl_nxt = rollover
                 || (ovfl_r && !(wr_stat && REG_WDATA[IRT_ST_OV]));
   wire [1:0] gap_nxt = (qual || !rx_run) ? 2'h0
                      : (car_end && gap_r != IRT_GAP_LIM)
                        ? 2'(gap_r + 2'h1) : gap_r;

   ////////////////////////////////////////////////////////////////
   // Pin outputs.
   wire car_out  = phase_r ^ poll_r;
   wire env_mode = (envsel == IRT_ENV_MOD) || (envsel == IRT_ENV_RAW);
   wire tx_nxt =
        !en ? pwr_r[IRT_PW_LVL]
      : !mode ? pol
      : (envsel == IRT_ENV_RAW) ? car_out
      : datl_r ? car_out
      : poll_r;
   wire oen_nxt = en ? 1'b0 : !pwr_r[IRT_PW_OE];
   wire env_nxt = tx_run && env_mode
                  && (datl_r ^ poll_r);

   // Read data mux; unmapped addresses read zero.
   wire [31:0] rd_mux =
        (REG_ADDR == IRT_CTRL_ADDR) ? {18'h0, ctrl_r}
      : (REG_ADDR == IRT_STAT_ADDR) ? {30'h0, ovfl_r, intf_r}
      : (REG_ADDR == IRT_CARR_ADDR) ? {16'h0, carr_r}
      : (REG_ADDR == IRT_MODT_ADDR) ? {16'h0, modt_r}
      : (REG_ADDR == IRT_CNTV_ADDR) ? {16'h0, cntv_r}
      : (REG_ADDR == IRT_PWRC_ADDR) ? {30'h0, pwr_r}
      : 32'h0;

   ////////////////////////////////////////////////////////////////
   // Software registers.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         ctrl_r <= IRT_CTRL_RST;
         carr_r <= IRT_W16_ZERO;
         modt_r <= IRT_W16_ZERO;
         cntv_r <= IRT_W16_ZERO;
         pwr_r  <= 2'h0;
         intf_r <= 1'b0;
         ovfl_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         carr_r <= wr_carr ? wd16 : carr_r;
         modt_r <= modt_nxt;
         cntv_r <= cntv_nxt;
         pwr_r  <= wr_pwrc ? REG_WDATA[1:0] : pwr_r;
         intf_r <= intf_nxt;
         ovfl_r <= ovfl_nxt;
      end
   end

   // Carrier generator and transmit latches.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pre_r     <= 3'h0;
         phase_r   <= 1'b1;
         ccnt_r    <= 8'h00;
         carl_r    <= IRT_W16_ZERO;
         datl_r    <= 1'b0;
         poll_r    <= 1'b0;
         txrun_q_r <= 1'b0;
      end else begin
         pre_r     <= 3'(pre_r + 3'h1);
         phase_r   <= phase_nxt;
         ccnt_r    <= ccnt_nxt;
         carl_r    <= carl_nxt;
         datl_r    <= tx_lat ? ctrl_r[IRT_DATA] : datl_r;
         poll_r    <= tx_lat ? pol : poll_r;
         txrun_q_r <= tx_run;
      end
   end

   // Receive synchroniser and edge bookkeeping.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rx_s1_r   <= 1'b0;
         rx_s2_r   <= 1'b0;
         rx_s3_r   <= 1'b0;
         started_r <= 1'b0;
         gap_r     <= 2'h0;
      end else begin
         rx_s1_r   <= IR_RX_PIN;
         rx_s2_r   <= rx_s1_r;
         rx_s3_r   <= rx_s2_r;
         started_r <= rx_run && (started_r || qual);
         gap_r     <= gap_nxt;
      end
   end

   // Registered pins and read data, held in the cycle after a read only.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rdata_r <= 32'h0;
         tx_r    <= 1'b0;
         oen_r   <= 1'b1;
         env_r   <= 1'b0;
      end else begin
         rdata_r <= REG_RD ? rd_mux : 32'h0;
         tx_r    <= tx_nxt;
         oen_r   <= oen_nxt;
         env_r   <= env_nxt;
      end
   end

   assign REG_RDATA        = rdata_r;
   assign IR_TX_PIN        = tx_r;
   assign IR_TX_OE_N       = oen_r;
   assign ENVELOPE_OUT_PIN = env_r;
   assign IR_IRQ           = ie && (intf_r || ovfl_r);

   ////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   property p_manual;
      !en |=> IR_TX_PIN == $past(pwr_r[IRT_PW_LVL])
              && IR_TX_OE_N == !$past(pwr_r[IRT_PW_OE]);
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual pin level wrong");

   property p_start;
      tx_start && !wr_modt |=> cntv_r == $past(modt_r);
   endproperty
   a_start: assert property (p_start)
      else $error("transmit start load wrong");

   property p_reload;
      tx_rel |=> intf_r && cntv_r == $past(modt_r)
                 && datl_r == $past(ctrl_r[IRT_DATA]);
   endproperty
   a_reload: assert property (p_reload)
      else $error("interval reload wrong");

   property p_ovf;
      rollover |=> ovfl_r ##0 IR_IRQ == ie;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow flag missing");

   property p_first;
      first_ev |=> started_r && cntv_r == IRT_W16_ZERO;
   endproperty
   a_first: assert property (p_first)
      else $error("first edge handling wrong");

   property p_capture;
      capture |=> modt_r == $past(cntv_r) && intf_r
                  && ctrl_r[IRT_DATA] == $past(rx_s2_r);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture wrong");

   property p_burst_on;
      burst_on |=> modt_r == IRT_W16_ONE;
   endproperty
   a_burst_on: assert property (p_burst_on)
      else $error("burst start load wrong");

   property p_idle;
      en && !mode |=> IR_TX_PIN == $past(pol) && !IR_TX_OE_N;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle level wrong");

   property p_envelope;
      tx_run && env_mode ##1 tx_run && env_mode
         |=> ENVELOPE_OUT_PIN == $past(datl_r ^ poll_r);
   endproperty
   a_envelope: assert property (p_envelope)
      else $error("envelope level wrong");

   property p_env_off;
      !(tx_run && env_mode) |=> !ENVELOPE_OUT_PIN;
   endproperty
   a_env_off: assert property (p_env_off)
      else $error("envelope pin active outside envelope mode");

   property p_raw_carrier;
      tx_run && envsel == IRT_ENV_RAW |=> IR_TX_PIN == $past(car_out);
   endproperty
   a_raw_carrier: assert property (p_raw_carrier)
      else $error("unmodulated carrier missing");

   property p_tx_step;
      tx_run && !tx_start && cclk && cntv_r != IRT_W16_ZERO |=> cntv_r == 16'($past(cntv_r) - IRT_W16_ONE);
   endproperty
   a_tx_step: assert property (p_tx_step)
      else $error("transmit down count wrong");

   property p_rx_step;
      rx_inc && !later_ev |=> cntv_r == 16'($past(cntv_r) + IRT_W16_ONE);
   endproperty
   a_rx_step: assert property (p_rx_step)
      else $error("receive up count wrong");

   property p_clear;
      later_ev && reload |=> cntv_r == IRT_W16_ZERO;
   endproperty
   a_clear: assert property (p_clear)
      else $error("capture clear wrong");

   property p_burst_cnt;
      rx_run && burst && qual && !burst_on |=> modt_r == 16'($past(modt_r) + IRT_W16_ONE);
   endproperty
   a_burst_cnt: assert property (p_burst_cnt)
      else $error("burst edge count wrong");

   property p_gap;
      gap_ev |=> intf_r;
   endproperty
   a_gap: assert property (p_gap)
      else $error("gap flag missing");

   property p_flag_keep;
      if_set && wr_stat && REG_WDATA[IRT_ST_IF] |=> intf_r;
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("flag lost to a clear");

endmodule : irt_top
`default_nettype wire
